// ==== core/hilc_top.sv ====
`timescale 1ns/1ps
`include "hilc_defs.svh"
// How it works
// - Each terminal with interrupts gets its own 2-word log entry.
// - Output-enabled interrupts from all terminals are ORed onto one host interrupt.
// - Log holds 32 entries at 0x0180-0x01BF, info even, address odd.
// - Pointer wraps to 0x0180 after the 32nd entry completes.
// - Master or software reset sets log pointer to 0x0180.
// - Enable and output enable bits 4-0 are read-only to the host.
// - Pending bits 2-0 follow terminal pending registers.
// - Bit 15 sets on a serial host transfer with a bad clock count.
// - Bit 14 is checksum flag only if protection pin low, boot pin high.
// - Bit 14 of enable and output enable reads 1 after master reset.
// - Checksum failure sets bit 14 and master status bit 1.
// - Protection pin high shrinks RAM to 24K and enables error correction.
// - Single-bit errors corrected silently; multi-bit error sets bit 14.
// - Master status bit 1 tells checksum error from RAM error.
// - Hardware entries log address zero, RAM errors log the error address.
module hilc_top (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_sw_rst,
  input wire logic i_ram_protection_select_pin,
  input wire logic i_auto_boot_pin,
  input wire logic [15:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [15:0] i_reg_wdata,
  output logic [15:0] o_reg_rdata,
  input wire logic [2:0] i_term_pend,
  input wire logic [2:0] i_term_en,
  input wire logic [2:0] i_term_oe,
  input wire logic [2:0] i_term_evt,
  input wire hilc_pkg::hilc_entry_type [2:0] i_term_entry,
  input wire logic i_serial_fault,
  input wire logic i_cksum_fail,
  input wire logic i_ram_multi_err,
  input wire logic i_ram_single_err,
  input wire logic [15:0] i_ram_err_addr,
  input wire logic i_mstat_clr,
  output logic o_mstat_cksum,
  output logic o_edc_on,
  output logic [15:0] o_ram_top,
  output hilc_pkg::hilc_ram_wr_type o_log_wr,
  output logic o_irq
);
  import hilc_pkg::*;

  // ----------------------------------------
  // Pin synchronisers and straps
  // ----------------------------------------
  logic [2:0] prot_sync_q;
  logic [2:0] boot_sync_q;
  logic strap_done_q;
  logic cksum_mode_q;
  logic edc_mode_q;

  always_ff @(posedge i_mclk) begin
    prot_sync_q <= {prot_sync_q[1:0], i_ram_protection_select_pin};
    boot_sync_q <= {boot_sync_q[1:0], i_auto_boot_pin};
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      strap_done_q <= 1'b0;
      cksum_mode_q <= 1'b0;
      edc_mode_q <= 1'b0;
    end else if (!strap_done_q && prot_sync_q[2] == prot_sync_q[1]
                 && boot_sync_q[2] == boot_sync_q[1]) begin
      strap_done_q <= 1'b1;
      cksum_mode_q <= !prot_sync_q[2] && boot_sync_q[2];
      edc_mode_q <= prot_sync_q[2];
    end
  end

  // RAM size and correction mode
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_edc_on <= 1'b0;
      o_ram_top <= `HILC_RAM_TOP_32K;
    end else begin
      o_edc_on <= edc_mode_q;
      o_ram_top <= edc_mode_q ? `HILC_RAM_TOP_24K : `HILC_RAM_TOP_32K;
    end
  end

  // ----------------------------------------
  // Hardware interrupt registers
  // ----------------------------------------
  logic [15:0] pend_q;
  logic [15:0] en_q;
  logic [15:0] oe_q;
  logic wr_pend;
  logic wr_en;
  logic wr_oe;
  logic set_serial;
  logic set_b14;
  logic [15:0] pend_rd;
  logic [15:0] en_rd;
  logic [15:0] oe_rd;

  assign wr_pend = i_reg_wr && i_reg_addr == `HILC_OFS_PEND;
  assign wr_en = i_reg_wr && i_reg_addr == `HILC_OFS_EN;
  assign wr_oe = i_reg_wr && i_reg_addr == `HILC_OFS_OE;
  assign set_serial = i_serial_fault;
  // Single-bit errors never raise a flag
  assign set_b14 = (cksum_mode_q && i_cksum_fail) || (edc_mode_q && i_ram_multi_err);
  assign pend_rd = {pend_q[15:3], i_term_pend};
  assign en_rd = {en_q[15:5], 2'b00, i_term_en};
  assign oe_rd = {oe_q[15:5], 2'b00, i_term_oe};

  // Write one to clear, a set in the same cycle wins
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      pend_q <= 16'h0000;
    end else begin
      pend_q[`HILC_BIT_SERIAL] <= set_serial
        || (pend_q[`HILC_BIT_SERIAL] && !(wr_pend && i_reg_wdata[`HILC_BIT_SERIAL]));
      pend_q[`HILC_BIT_B14] <= set_b14
        || (pend_q[`HILC_BIT_B14] && !(wr_pend && i_reg_wdata[`HILC_BIT_B14]));
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      en_q <= `HILC_EN_RST;
    end else if (wr_en) begin
      en_q <= i_reg_wdata & `HILC_WR_MASK;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      oe_q <= `HILC_OE_RST;
    end else if (wr_oe) begin
      oe_q <= i_reg_wdata & `HILC_WR_MASK;
    end
  end

  // Master status checksum bit
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_mstat_cksum <= 1'b0;
    end else if (cksum_mode_q && i_cksum_fail) begin
      o_mstat_cksum <= 1'b1;
    end else if (i_mstat_clr) begin
      o_mstat_cksum <= 1'b0;
    end
  end

  // Register read port
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_reg_rdata <= 16'h0000;
    end else if (i_reg_rd) begin
      unique case (i_reg_addr)
        `HILC_OFS_PEND: o_reg_rdata <= pend_rd;
        `HILC_OFS_EN: o_reg_rdata <= en_rd;
        `HILC_OFS_OE: o_reg_rdata <= oe_rd;
        default: o_reg_rdata <= 16'h0000;
      endcase
    end
  end

  // ----------------------------------------
  // Host interrupt output
  // ----------------------------------------
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(pend_q & en_q & oe_q & `HILC_HW_MASK)
        || |(i_term_pend & i_term_oe);
    end
  end

  // ----------------------------------------
  // Log requests
  // ----------------------------------------
  logic [3:0] req_q;
  hilc_entry_type [3:0] ent_q;
  logic [3:0] hw_new;
  logic [1:0] sel;
  logic [3:0] grant;
  hilc_state_type state_q;
  logic [`HILC_LOG_IDX_W-1:0] idx_q;
  hilc_entry_type cur_q;

  // Hardware entry, slot 3; terminals in slots 0 to 2
  assign hw_new[2:0] = i_term_evt;
  assign hw_new[3] = (set_serial && en_q[`HILC_BIT_SERIAL])
    || (set_b14 && en_q[`HILC_BIT_B14]);

  function automatic logic [1:0] pick(input logic [3:0] r);
    if (r[3]) begin
      pick = 2'd3;
    end else if (r[0]) begin
      pick = 2'd0;
    end else if (r[1]) begin
      pick = 2'd1;
    end else begin
      pick = 2'd2;
    end
  endfunction

  assign sel = pick(req_q);
  // Grant at entry start, so both words come from one slot
  assign grant = (state_q == HILC_IDLE && |req_q && !i_sw_rst) ? (4'b0001 << sel) : 4'b0000;

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      req_q <= 4'b0000;
      ent_q <= '0;
      cur_q <= '0;
    end else begin
      if (|grant) begin
        cur_q <= ent_q[sel];
      end
      for (int i = 0; i < 3; i++) begin
        if (hw_new[i]) begin
          req_q[i] <= 1'b1;
          ent_q[i].info <= (req_q[i] && !grant[i]) ?
            (ent_q[i].info | i_term_entry[i].info) : i_term_entry[i].info;
          ent_q[i].addr <= i_term_entry[i].addr;
        end else if (grant[i]) begin
          req_q[i] <= 1'b0;
        end
      end
      if (hw_new[3]) begin
        req_q[3] <= 1'b1;
        ent_q[3].info <= ((req_q[3] && !grant[3]) ? ent_q[3].info : 16'h0000)
          | {set_serial, set_b14, 14'h0000};
        ent_q[3].addr <= (edc_mode_q && i_ram_multi_err) ?
          i_ram_err_addr : `HILC_HW_IAW;
      end else if (grant[3]) begin
        req_q[3] <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Log writer
  // ----------------------------------------
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst || i_sw_rst) begin
      state_q <= HILC_IDLE;
    end else begin
      unique case (state_q)
        HILC_IDLE: if (|req_q) state_q <= HILC_INFO;
        HILC_INFO: state_q <= HILC_ADDR;
        HILC_ADDR: state_q <= HILC_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst || i_sw_rst) begin
      idx_q <= '0;
    end else if (state_q == HILC_ADDR) begin
      idx_q <= idx_q + 1'b1;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst || i_sw_rst) begin
      o_log_wr <= '0;
    end else begin
      o_log_wr.we <= state_q != HILC_IDLE;
      o_log_wr.addr <= `HILC_LOG_BASE
        + {10'h000, idx_q, state_q == HILC_ADDR};
      o_log_wr.data <= (state_q == HILC_ADDR) ? cur_q.addr : cur_q.info;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  log_range_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    o_log_wr.we |-> o_log_wr.addr >= `HILC_LOG_BASE && o_log_wr.addr <= `HILC_LOG_LAST)
    else $error("log write outside log area");
  info_then_addr_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst || i_sw_rst)
    (o_log_wr.we && !o_log_wr.addr[0]) |=> (o_log_wr.we && o_log_wr.addr[0]))
    else $error("address word did not follow info word");
  wrap_ptr_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst || i_sw_rst)
    (o_log_wr.we && o_log_wr.addr == `HILC_LOG_LAST) |-> idx_q == '0)
    else $error("pointer did not wrap");
  ptr_reset_a: assert property (@(posedge i_mclk)
    (i_sys_rst || i_sw_rst) |=> idx_q == '0)
    else $error("pointer not at log start after reset");
  ro_bits_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    wr_en |=> en_q[`HILC_RO_MSB:0] == 5'h00)
    else $error("read-only enable bits changed");
  serial_flag_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    i_serial_fault |=> pend_q[`HILC_BIT_SERIAL])
    else $error("serial fault flag not set");
  b14_reset_a: assert property (@(posedge i_mclk)
    i_sys_rst |=> en_q[`HILC_BIT_B14] && oe_q[`HILC_BIT_B14])
    else $error("bit 14 enables not set after reset");
  cksum_pair_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    (cksum_mode_q && i_cksum_fail) |=> pend_q[`HILC_BIT_B14] && o_mstat_cksum)
    else $error("checksum failure not flagged");
  irq_or_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    (|(i_term_pend & i_term_oe)) |=> o_irq)
    else $error("terminal interrupt missed on output");
  single_quiet_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    (i_ram_single_err && !i_ram_multi_err && !i_cksum_fail && !pend_q[`HILC_BIT_B14]
     && !wr_pend) |=> !pend_q[`HILC_BIT_B14])
    else $error("single-bit error raised a flag");
  hw_iaw_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
    (hw_new[3] && !i_ram_multi_err) |=> ent_q[3].addr == `HILC_HW_IAW)
    else $error("hardware address word not zero");
endmodule

// ==== core/hilc_defs.svh ====
`ifndef HILC_DEFS_SVH
`define HILC_DEFS_SVH
// ----------------------------------------
// Register word offsets
// ----------------------------------------
`define HILC_OFS_PEND 16'h0006
`define HILC_OFS_EN 16'h000f
`define HILC_OFS_OE 16'h0013
// ----------------------------------------
// Bit positions and reset values
// ----------------------------------------
`define HILC_BIT_SERIAL 15
`define HILC_BIT_B14 14
`define HILC_RO_MSB 4
`define HILC_WR_MASK 16'hffe0
`define HILC_EN_RST 16'h4000
`define HILC_OE_RST 16'h4000
`define HILC_HW_MASK 16'hc000
// ----------------------------------------
// Log area
// ----------------------------------------
`define HILC_LOG_BASE 16'h0180
`define HILC_LOG_LAST 16'h01bf
`define HILC_LOG_ENTRIES 32
`define HILC_LOG_IDX_W 5
`define HILC_HW_IAW 16'h0000
// ----------------------------------------
// RAM size limits
// ----------------------------------------
`define HILC_RAM_TOP_32K 16'h7fff
`define HILC_RAM_TOP_24K 16'h5fff
`endif

// ==== core/hilc_pkg.sv ====
package hilc_pkg;
  typedef enum logic [1:0] {
    HILC_IDLE = 2'b00,
    HILC_INFO = 2'b01,
    HILC_ADDR = 2'b11
  } hilc_state_type;

  typedef struct packed {
    logic [15:0] info;
    logic [15:0] addr;
  } hilc_entry_type;

  typedef struct packed {
    logic we;
    logic [15:0] addr;
    logic [15:0] data;
  } hilc_ram_wr_type;
endpackage

// ==== verification/hilc_host.sv ====
`timescale 1ns/1ps
// ----------------------------------------
// Host side of the register strobe port
// ----------------------------------------
module hilc_host (
  input wire logic i_mclk,
  input wire logic [15:0] i_rdata,
  output logic [15:0] o_addr,
  output logic o_wr,
  output logic o_rd,
  output logic [15:0] o_wdata
);
  initial begin
    o_addr = 16'h0000;
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_wdata = 16'h0000;
  end
  // One write strobe, held across one edge
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge i_mclk);
    #1;
    o_addr = a;
    o_wdata = d;
    o_wr = 1'b1;
    @(posedge i_mclk);
    #1;
    o_wr = 1'b0;
  endtask
  // Read strobe, data taken after the answer edge
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(posedge i_mclk);
    #1;
    o_addr = a;
    o_rd = 1'b1;
    @(posedge i_mclk);
    #1;
    o_rd = 1'b0;
    d = i_rdata;
  endtask
endmodule

// ==== verification/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
  import hilc_pkg::*;
  logic i_mclk = 1'b0;
  logic rst = 1'b1, sw = 1'b0, prot = 1'b0, boot = 1'b1, sf = 1'b0, ckf = 1'b0;
  logic merr = 1'b0, serr = 1'b0, mclr = 1'b0, mstat, edc, irq, rwr, rrd;
  logic [2:0] tpend = 3'h0, ten = 3'h5, toe = 3'h3, tevt = 3'h0;
  logic [15:0] eaddr = 16'h0000, raddr, wdata, rdata, rtop, v;
  logic [15:0] lf = 16'h0028;
  logic [4:0] lp = 5'h00;
  hilc_entry_type [2:0] tent = '0;
  hilc_ram_wr_type lwr;
  logic [31:0] expq[$];
  logic [31:0] e;
  int err_total = 0, num_checks = 0, cyc = 0;

  initial forever #10 i_mclk = ~i_mclk;

  hilc_host host (.i_mclk(i_mclk), .i_rdata(rdata), .o_addr(raddr), .o_wr(rwr),
    .o_rd(rrd), .o_wdata(wdata));
  hilc_top dut (.i_mclk(i_mclk), .i_sys_rst(rst), .i_sw_rst(sw),
    .i_ram_protection_select_pin(prot), .i_auto_boot_pin(boot), .i_reg_addr(raddr),
    .i_reg_wr(rwr), .i_reg_rd(rrd), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
    .i_term_pend(tpend), .i_term_en(ten), .i_term_oe(toe), .i_term_evt(tevt),
    .i_term_entry(tent), .i_serial_fault(sf), .i_cksum_fail(ckf),
    .i_ram_multi_err(merr), .i_ram_single_err(serr), .i_ram_err_addr(eaddr),
    .i_mstat_clr(mclr), .o_mstat_cksum(mstat), .o_edc_on(edc), .o_ram_top(rtop),
    .o_log_wr(lwr), .o_irq(irq));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [15:0] nxt(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] x);
    num_checks++;
    if (got !== x) begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, x);
      err_total++;
    end
  endtask
  task automatic expent(input logic [15:0] info, input logic [15:0] adr);
    expq.push_back({16'h0180 + {10'h000, lp, 1'b0}, info});
    expq.push_back({16'h0181 + {10'h000, lp, 1'b0}, adr});
    lp = lp + 5'h01;
  endtask
  task automatic rdchk(input logic [15:0] a, input logic [15:0] x);
    host.rd(a, v);
    chk(v, x);
  endtask
  task automatic do_reset(input logic p);
    prot = p;
    rst = 1'b1;
    tick(2);
    rst = 1'b0;
    lp = 5'h00;
    tick(6);
  endtask
  task automatic burst();
    for (int i = 0; i < 3; i++) begin
      lf = nxt(lf);
      tent[i].info = lf;
      lf = nxt(lf);
      tent[i].addr = lf;
      expent(tent[i].info, tent[i].addr);
    end
    tevt = 3'h7;
    tick(1);
    tevt = 3'h0;
    tick(12);
  endtask
  task automatic results();
    $display("checks=%0d errors=%0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // ----------------------------------------
  // Log write monitor
  // ----------------------------------------
  always @(posedge i_mclk) begin
    if (lwr.we === 1'b1) begin
      e = (expq.size() > 0) ? expq.pop_front() : 32'hffffffff;
      chk(lwr.addr, e[31:16]);
      chk(lwr.data, e[15:0]);
    end
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      results();
    end
  end

  initial begin
    do_reset(1'b0);
    chk({15'h0000, edc}, 16'h0000);
    chk(rtop, 16'h7fff);
    rdchk(16'h000f, 16'h4005);
    rdchk(16'h0013, 16'h4003);
    host.wr(16'h000f, 16'hffff);
    rdchk(16'h000f, 16'hffe5);
    host.wr(16'h0013, 16'h801f);
    rdchk(16'h0013, 16'h8003);
    rdchk(16'h0001, 16'h0000);
    expent(16'h4000, 16'h0000);
    ckf = 1'b1;
    tick(1);
    ckf = 1'b0;
    tick(8);
    chk({15'h0000, mstat}, 16'h0001);
    rdchk(16'h0006, 16'h4000);
    chk({15'h0000, irq}, 16'h0000);
    mclr = 1'b1;
    tick(1);
    mclr = 1'b0;
    tick(2);
    chk({15'h0000, mstat}, 16'h0000);
    host.wr(16'h0006, 16'hc000);
    expent(16'h8000, 16'h0000);
    sf = 1'b1;
    tick(1);
    sf = 1'b0;
    tick(8);
    rdchk(16'h0006, 16'h8000);
    chk({15'h0000, irq}, 16'h0001);
    host.wr(16'h0006, 16'hc000);
    tick(3);
    chk({15'h0000, irq}, 16'h0000);
    tpend = 3'h6;
    tick(3);
    chk({15'h0000, irq}, 16'h0001);
    rdchk(16'h0006, 16'h0006);
    tpend = 3'h0;
    repeat (11) burst();
    sw = 1'b1;
    tick(1);
    sw = 1'b0;
    lp = 5'h00;
    tick(2);
    burst();
    do_reset(1'b1);
    chk({15'h0000, edc}, 16'h0001);
    chk(rtop, 16'h5fff);
    lf = nxt(lf);
    eaddr = lf;
    expent(16'h4000, lf);
    merr = 1'b1;
    tick(1);
    merr = 1'b0;
    serr = 1'b1;
    ckf = 1'b1;
    tick(1);
    serr = 1'b0;
    ckf = 1'b0;
    tick(8);
    rdchk(16'h0006, 16'h4000);
    chk({15'h0000, mstat}, 16'h0000);
    chk(16'(expq.size()), 16'h0000);
    results();
  end
endmodule
